/* File: srtmr_pkg.sv */
// Package for the reload/capture timer: register map, field layout, types.
// Assumes an APB master with 32-bit data and word-aligned registers.
// Notes on behaviour
// - Counter is two separately accessible 8-bit halves.
// - 16-bit mode overflow loads both reload bytes.
// - Every 16-bit overflow sets high overflow flag.
// - Timer interrupt enable raises interrupt on overflow.
// - Low byte wrap interrupts when low enable set.
// - Four clocks; slow ones synchronised to system clock.
// - Split mode: two 8-bit auto-reload counters.
// - Split: run bit gates high half only.
// - Fast select picks system clock, else external select.
// - Split: each half wrap sets its own flag.
// - Split: interrupt on high, or either with enable.
// - Flags cleared only by software, never hardware.
// - Capture mode entered by writing capture enable.
// - Capture on comparator edge or 8 rtc cycles.
// - Capture copies counter to reload, sets high flag.
// - Capture enable is control register bit 4.
package srtmr_pkg;

  // Register byte addresses.
  localparam logic [7:0] SRTMR_OFS_CTRL = 8'h00;
  localparam logic [7:0] SRTMR_OFS_CNT_LO = 8'h04;
  localparam logic [7:0] SRTMR_OFS_CNT_HI = 8'h08;
  localparam logic [7:0] SRTMR_OFS_RLD_LO = 8'h0c;
  localparam logic [7:0] SRTMR_OFS_RLD_HI = 8'h10;
  localparam logic [7:0] SRTMR_OFS_CLKCON = 8'h14;
  localparam logic [7:0] SRTMR_OFS_IEN = 8'h18;
  localparam logic [7:0] SRTMR_OFS_STAT = 8'h1c;
  localparam logic [7:0] SRTMR_OFS_MASK = 8'h20;

  // Timer control register fields.
  localparam int SRTMR_B_HOVF = 7;
  localparam int SRTMR_B_LOVF = 6;
  localparam int SRTMR_B_LOIEN = 5;
  localparam int SRTMR_B_CAPEN = 4;
  localparam int SRTMR_B_SPLIT = 3;
  localparam int SRTMR_B_RUN = 2;
  // Clock control register fields.
  localparam int SRTMR_B_HFAST = 1;
  localparam int SRTMR_B_LFAST = 0;
  // Global interrupt enable register field.
  localparam int SRTMR_B_TIEN = 5;
  // Sticky status and mask fields.
  localparam int SRTMR_S_HOVF = 0;
  localparam int SRTMR_S_LOVF = 1;
  localparam int SRTMR_S_CAP = 2;
  localparam int SRTMR_STAT_W = 3;

  localparam logic [7:0] SRTMR_RST_BYTE = 8'h00;
  localparam logic [1:0] SRTMR_XSEL_DIV12 = 2'h0;
  localparam logic [1:0] SRTMR_XSEL_RTC8 = 2'h1;
  localparam logic [1:0] SRTMR_XSEL_CMP = 2'h3;
  localparam int SRTMR_SYS_DIV = 12;
  localparam int SRTMR_RTC_DIV = 8;

  typedef struct packed {
    logic [31:0] paddr;
    logic pwrite;
    logic [31:0] pwdata;
  } srtmr_req_t;

  typedef struct packed {
    logic h;
    logic l;
  } srtmr_tick_t;

endpackage

/* File: srtmr_tb.sv */
// Self-checking bench for the reload/capture timer with an integer model.
// Drives APB, comparator and rtc inputs itself; clk_en stays high.
`timescale 1ns/100ps
`default_nettype none
module testbench;
  localparam logic [7:0] CTL = srtmr_pkg::SRTMR_OFS_CTRL;
  localparam logic [7:0] CLO = srtmr_pkg::SRTMR_OFS_CNT_LO;
  localparam logic [7:0] CHI = srtmr_pkg::SRTMR_OFS_CNT_HI;
  localparam logic [7:0] RLO = srtmr_pkg::SRTMR_OFS_RLD_LO;
  localparam logic [7:0] RHI = srtmr_pkg::SRTMR_OFS_RLD_HI;
  localparam logic [7:0] IEN = srtmr_pkg::SRTMR_OFS_IEN;
  localparam logic [7:0] STA = srtmr_pkg::SRTMR_OFS_STAT;
  localparam logic [7:0] MSK = srtmr_pkg::SRTMR_OFS_MASK;
  logic pclk = 1'b0, presetn = 1'b0, clk_en = 1'b1, psel = 1'b0;
  logic penable = 1'b0, pwrite = 1'b0, rtc_clk_in = 1'b0, cmp0_in = 1'b0;
  logic [31:0] paddr = 32'h0, pwdata = 32'h0, prdata, rd, seed = 32'h28;
  logic pready, pslverr, timer_irq, irq, er;
  int error_cnt = 0, total_checks = 0, m_cnt, rl;
  always #50 pclk = ~pclk;
  srtmr_timer u_srtmr_timer (.pclk(pclk), .presetn(presetn), .clk_en(clk_en),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .rtc_clk_in(rtc_clk_in), .cmp0_in(cmp0_in), .timer_irq(timer_irq),
    .irq(irq));
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  function automatic int inc(int c, int r);
    return (c == 65535) ? r : c + 1;
  endfunction
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {24'h0, a};
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
    @(posedge pclk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(rd, e);
  endtask
  task automatic pul(input int k, input logic r);
    repeat (k) begin
      if (r) rtc_clk_in <= 1'b1;
      else cmp0_in <= 1'b1;
      repeat (4) @(posedge pclk);
      if (r) rtc_clk_in <= 1'b0;
      else cmp0_in <= 1'b0;
      repeat (4) @(posedge pclk);
    end
    repeat (4) @(posedge pclk);
  endtask
  task automatic print_verdict();
    $display("checks=%0d errors=%0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  initial begin
    #500000;
    error_cnt++;
    print_verdict();
  end
  initial begin
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    for (int a = 0; a <= 32; a += 4) rdc(a[7:0], 32'h0);
    apb(1'b0, 8'h40, 32'h0);
    chk({31'h0, er}, 32'h1);
    rl = xs() & 32'hffff;
    m_cnt = 32'hfffe;
    wr(IEN, 32'h20);
    wr(MSK, 32'h7);
    wr(RLO, rl & 255);
    wr(RHI, rl >> 8);
    wr(CLO, 32'hfe);
    wr(CHI, 32'hff);
    wr(CTL, 32'h07);
    pul(3, 1'b0);
    repeat (3) m_cnt = inc(m_cnt, rl);
    rdc(CLO, m_cnt & 255);
    rdc(CHI, m_cnt >> 8);
    rdc(CTL, 32'hc7);
    chk({31'h0, timer_irq}, 32'h1);
    chk({31'h0, irq}, 32'h1);
    rdc(STA, 32'h3);
    @(posedge pclk);
    chk({31'h0, irq}, 32'h0);
    wr(CTL, 32'h47);
    chk({31'h0, timer_irq}, 32'h0);
    wr(CTL, 32'h67);
    rdc(CTL, 32'h67);
    chk({31'h0, timer_irq}, 32'h1);
    wr(CTL, 32'h0);
    wr(RLO, 32'h10);
    wr(RHI, 32'h20);
    wr(CLO, 32'hff);
    wr(CHI, 32'hff);
    wr(CTL, 32'h0b);
    pul(1, 1'b0);
    rdc(CLO, 32'h10);
    rdc(CHI, 32'hff);
    rdc(CTL, 32'h4b);
    chk({31'h0, timer_irq}, 32'h0);
    wr(CTL, 32'h6b);
    chk({31'h0, timer_irq}, 32'h1);
    wr(CTL, 32'h2f);
    pul(1, 1'b0);
    rdc(CLO, 32'h11);
    rdc(CHI, 32'h20);
    rdc(CTL, 32'haf);
    wr(CTL, 32'h0);
    rdc(STA, 32'h3);
    wr(MSK, 32'h0);
    m_cnt = xs() & 32'hffff;
    wr(CLO, m_cnt & 255);
    wr(CHI, m_cnt >> 8);
    wr(CTL, 32'h16);
    pul(1, 1'b0);
    rdc(RLO, m_cnt & 255);
    rdc(RHI, m_cnt >> 8);
    rdc(CTL, 32'h96);
    rdc(CLO, m_cnt & 255);
    chk({31'h0, irq}, 32'h0);
    wr(MSK, 32'h4);
    chk({31'h0, irq}, 32'h1);
    chk({31'h0, timer_irq}, 32'h1);
    wr(IEN, 32'h0);
    chk({31'h0, timer_irq}, 32'h0);
    apb(1'b0, STA, 32'h0);
    chk({31'h0, rd[2]}, 32'h1);
    @(posedge pclk);
    chk({31'h0, irq}, 32'h0);
    wr(CTL, 32'h0);
    wr(CLO, 32'hff);
    wr(CHI, 32'h0);
    wr(CTL, 32'h05);
    pul(16, 1'b1);
    rdc(CLO, 32'h1);
    rdc(CHI, 32'h1);
    wr(CTL, 32'h0);
    wr(srtmr_pkg::SRTMR_OFS_CLKCON, 32'h1);
    wr(CLO, 32'h0);
    wr(CHI, 32'h0);
    wr(CTL, 32'h15);
    pul(8, 1'b1);
    rdc(CTL, 32'h95);
    rdc(RHI, 32'h0);
    print_verdict();
  end
endmodule
`default_nettype wire

/* File: srtmr_timer.sv */
// Sixteen-bit reload/capture timer with an APB register slave.
// Assumes rtc_clk_in and cmp0_in are asynchronous to pclk.
// Assumes an APB master that holds each request until pready is high.
// Assumes clk_en is made in the pclk domain and freezes every flop.
// Registers are byte wide; the upper bits of a word read as zero.
`timescale 1ns/100ps
`default_nettype none
module srtmr_timer (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  // APB slave side.
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Asynchronous sources; each passes a two-flop synchroniser.
  input wire logic rtc_clk_in,
  input wire logic cmp0_in,
  // Level interrupt lines.
  output logic timer_irq,
  output logic irq
);

  // --------------------------------------------------------------------
  // Registers.
  // --------------------------------------------------------------------
  // Software-visible registers; the counter bytes also count.
  logic [7:0] counter_low_byte_r;
  logic [7:0] counter_high_byte_r;
  logic [7:0] reload_low_byte_r;
  logic [7:0] reload_high_byte_r;
  logic [7:0] timer_control_reg_r;
  logic [1:0] clock_control_reg_r;
  // Only the timer enable bit of the global enable register is kept.
  logic global_tien_r;
  // Sticky status and its mask, laid out bit for bit alike.
  logic [srtmr_pkg::SRTMR_STAT_W-1:0] stat_r;
  logic [srtmr_pkg::SRTMR_STAT_W-1:0] mask_r;
  // Bus response and interrupt flops behind the output ports.
  logic [31:0] prdata_r;
  logic pready_r;
  logic pslverr_r;
  logic timer_irq_r;
  logic irq_r;

  // --------------------------------------------------------------------
  // Synchronisers and clock sources.
  // --------------------------------------------------------------------
  // Two-flop synchronisers and edge detectors for the async inputs.
  logic [1:0] rtc_sync_r;
  logic [1:0] cmp_sync_r;
  logic rtc_prev_r;
  logic cmp_prev_r;
  // Free-running divider that yields one pulse every twelfth cycle.
  logic [3:0] div12_r;
  // Counts synchronised rtc rising edges; its top bit is rtc / 8.
  logic [2:0] rtc_div_r;
  logic rtc_div8_prev_r;

  // Only the second stage of each synchroniser is read by logic.
  wire rtc_s = rtc_sync_r[1];
  wire cmp_s = cmp_sync_r[1];
  // One-cycle strobes for each clock source.
  wire rtc_rise = rtc_s & ~rtc_prev_r;
  wire cmp_rise = cmp_s & ~cmp_prev_r;
  wire div12_tick = (div12_r == 4'(srtmr_pkg::SRTMR_SYS_DIV - 1));
  wire rtc8_tick = rtc_rise &
                   (rtc_div_r == 3'(srtmr_pkg::SRTMR_RTC_DIV - 1));
  wire rtc_div8 = rtc_div_r[2];
  wire rtc8_rise = rtc_div8 & ~rtc_div8_prev_r;
  // The count tick fires when the divider's top bit rises, on the fourth
  // edge of each group of eight; the capture strobe fires on the eighth,
  // so the two never fall in the same cycle.

  // Decoded control fields.
  wire [1:0] xsel = timer_control_reg_r[1:0];
  wire split = timer_control_reg_r[srtmr_pkg::SRTMR_B_SPLIT];
  wire run = timer_control_reg_r[srtmr_pkg::SRTMR_B_RUN];
  wire capen = timer_control_reg_r[srtmr_pkg::SRTMR_B_CAPEN];
  wire loien = timer_control_reg_r[srtmr_pkg::SRTMR_B_LOIEN];

  // --------------------------------------------------------------------
  // Clock tick selection.
  // --------------------------------------------------------------------
  // Selects the count tick for one half from its fast-select bit.
  // The reserved external code gives no tick, so a half whose fast bit is clear stands still.
  function automatic logic sel_tick(input logic fast,
                                    input logic [1:0] xs,
                                    input logic d12,
                                    input logic r8,
                                    input logic cr);
    logic t;
    t = 1'b0;
    if (fast) begin
      t = 1'b1;
    end else begin
      unique case (xs)
        srtmr_pkg::SRTMR_XSEL_DIV12: t = d12;
        srtmr_pkg::SRTMR_XSEL_RTC8: t = r8;
        srtmr_pkg::SRTMR_XSEL_CMP: t = cr;
        default: t = 1'b0;
      endcase
    end
    return t;
  endfunction

  // Both halves share the external select; only the fast bits differ.
  // A fast half counts on every enabled pclk cycle.
  srtmr_pkg::srtmr_tick_t tick;
  assign tick.h = sel_tick(clock_control_reg_r[srtmr_pkg::SRTMR_B_HFAST],
                           xsel, div12_tick, rtc8_rise, cmp_rise);
  assign tick.l = sel_tick(clock_control_reg_r[srtmr_pkg::SRTMR_B_LFAST],
                           xsel, div12_tick, rtc8_rise, cmp_rise);

  // --------------------------------------------------------------------
  // Counting.
  // --------------------------------------------------------------------
  // In 16-bit mode the low half's clock drives the whole counter.
  // The high fast bit is ignored then, and the run bit gates the count.
  // In split mode the low half runs freely and only the high half obeys
  // the run bit.
  wire inc16 = ~split & run & tick.l;
  wire inc_l = split ? tick.l : inc16;
  wire inc_h8 = split & run & tick.h;
  wire lo_wrap = inc_l & (counter_low_byte_r == 8'hff);
  // In 16-bit mode the high byte wraps only when the low byte wraps in the same tick.
  wire hi_wrap16 = inc16 & lo_wrap & (counter_high_byte_r == 8'hff);
  wire hi_wrap8 = inc_h8 & (counter_high_byte_r == 8'hff);
  wire hi_wrap = hi_wrap16 | hi_wrap8;
  // A capture needs no count tick; it fires on the raw strobe.
  // Bit 1 of the external select: 0 picks the rtc, 1 comparator.
  wire cap_ev = capen & (xsel[1] ? cmp_rise : rtc8_tick);

  // Next counter value: the reload takes the place of the wrap to zero,
  // so after an overflow the counter shows the reload value, not 0x00 or 0x0000.
  logic [7:0] cnt_lo_nxt;
  logic [7:0] cnt_hi_nxt;
  always_comb begin
    cnt_lo_nxt = counter_low_byte_r;
    cnt_hi_nxt = counter_high_byte_r;
    if (split) begin
      if (inc_l) begin
        cnt_lo_nxt = lo_wrap ? reload_low_byte_r :
                     8'(counter_low_byte_r + 8'h01);
      end
      if (inc_h8) begin
        cnt_hi_nxt = hi_wrap8 ? reload_high_byte_r :
                     8'(counter_high_byte_r + 8'h01);
      end
    end else if (inc16) begin
      if (hi_wrap16) begin
        cnt_lo_nxt = reload_low_byte_r;
        cnt_hi_nxt = reload_high_byte_r;
      end else begin
        cnt_lo_nxt = 8'(counter_low_byte_r + 8'h01);
        // A low wrap without a high wrap carries into the high byte.
        if (lo_wrap) begin
          cnt_hi_nxt = 8'(counter_high_byte_r + 8'h01);
        end
      end
    end
  end

  // --------------------------------------------------------------------
  // APB decode.
  // --------------------------------------------------------------------
  // The request is carried as one struct from the bus pins.
  srtmr_pkg::srtmr_req_t req;
  assign req = '{paddr: paddr, pwrite: pwrite, pwdata: pwdata};
  // The access is taken in the first access cycle; pready follows one
  // cycle later. Read data and the read-clear of status are taken at the
  // first edge, so that no event between snapshot and clear is lost.
  // A write lands at the edge at which the master sees pready high.
  wire acc = psel & penable & ~pready_r;
  wire fin = psel & penable & pready_r;
  wire wr = fin & req.pwrite;
  wire rd = acc & ~req.pwrite;
  wire [7:0] a = req.paddr[7:0];
  wire hit_ctrl = (a == srtmr_pkg::SRTMR_OFS_CTRL);
  wire hit_clo = (a == srtmr_pkg::SRTMR_OFS_CNT_LO);
  wire hit_chi = (a == srtmr_pkg::SRTMR_OFS_CNT_HI);
  wire hit_rlo = (a == srtmr_pkg::SRTMR_OFS_RLD_LO);
  wire hit_rhi = (a == srtmr_pkg::SRTMR_OFS_RLD_HI);
  wire hit_ckc = (a == srtmr_pkg::SRTMR_OFS_CLKCON);
  wire hit_ien = (a == srtmr_pkg::SRTMR_OFS_IEN);
  wire hit_st = (a == srtmr_pkg::SRTMR_OFS_STAT);
  wire hit_msk = (a == srtmr_pkg::SRTMR_OFS_MASK);
  // Anything outside the nine words answers with pslverr; effects decode only paddr[7:0], so a matching low byte still acts.
  wire mapped = (req.paddr[31:8] == 24'h000000) & (hit_ctrl | hit_clo |
                hit_chi | hit_rlo | hit_rhi | hit_ckc | hit_ien |
                hit_st | hit_msk);
  wire [7:0] wb = req.pwdata[7:0];

  // --------------------------------------------------------------------
  // Read data selection.
  // --------------------------------------------------------------------
  // Later hits win, but the address decodes are exclusive.
  logic [31:0] rdata_sel;
  always_comb begin
    rdata_sel = 32'h00000000;
    if (hit_ctrl) rdata_sel = {24'h000000, timer_control_reg_r};
    if (hit_clo) rdata_sel = {24'h000000, counter_low_byte_r};
    if (hit_chi) rdata_sel = {24'h000000, counter_high_byte_r};
    if (hit_rlo) rdata_sel = {24'h000000, reload_low_byte_r};
    if (hit_rhi) rdata_sel = {24'h000000, reload_high_byte_r};
    if (hit_ckc) rdata_sel = {30'h00000000, clock_control_reg_r};
    if (hit_ien) rdata_sel = {26'h0000000, global_tien_r, 5'h00};
    if (hit_st) rdata_sel = {29'h00000000, stat_r};
    if (hit_msk) rdata_sel = {29'h00000000, mask_r};
  end

  // --------------------------------------------------------------------
  // Flags and interrupts.
  // --------------------------------------------------------------------
  // Hardware sets win over a software write of zero in the same cycle.
  wire w_ctrl = wr & hit_ctrl;
  // The high flag is set by a high wrap in either mode or by a capture.
  wire hflag_nxt = hi_wrap | cap_ev |
                   (w_ctrl ? wb[srtmr_pkg::SRTMR_B_HOVF] :
                    timer_control_reg_r[srtmr_pkg::SRTMR_B_HOVF]);
  // The low flag is set by any low-half wrap, whatever the mode.
  wire lflag_nxt = lo_wrap |
                   (w_ctrl ? wb[srtmr_pkg::SRTMR_B_LOVF] :
                    timer_control_reg_r[srtmr_pkg::SRTMR_B_LOVF]);
  // The other control bits are plain read/write.
  wire [5:0] ctrl_lo_nxt = w_ctrl ? wb[5:0] : timer_control_reg_r[5:0];
  // Status collects the same events as sticky bits for the mask path.
  wire [srtmr_pkg::SRTMR_STAT_W-1:0] ev = {cap_ev, lo_wrap, hi_wrap};
  // A read clears status, but an event in the same cycle still sets it.
  wire st_clr = rd & hit_st;
  wire [srtmr_pkg::SRTMR_STAT_W-1:0] stat_nxt = ev |
                                        (st_clr ? '0 : stat_r);
  // The timer line follows the control flags, not the status register,
  // so clearing a flag in the control register is what drops it.
  wire tirq_nxt = global_tien_r &
                  (timer_control_reg_r[srtmr_pkg::SRTMR_B_HOVF] |
                   (loien & timer_control_reg_r[srtmr_pkg::SRTMR_B_LOVF]));

  // --------------------------------------------------------------------
  // Synchroniser and divider flops.
  // --------------------------------------------------------------------
  // The first stages feed only the second; edge detectors read the
  // second stage and a delayed copy of it.

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rtc_sync_r <= 2'h0;
      cmp_sync_r <= 2'h0;
      rtc_prev_r <= 1'b0;
      cmp_prev_r <= 1'b0;
      rtc_div8_prev_r <= 1'b0;
    end else if (clk_en) begin
      // Each source is shifted through its two stages.
      rtc_sync_r <= {rtc_sync_r[0], rtc_clk_in};
      cmp_sync_r <= {cmp_sync_r[0], cmp0_in};
      rtc_prev_r <= rtc_s;
      cmp_prev_r <= cmp_s;
      rtc_div8_prev_r <= rtc_div8;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div12_r <= 4'h0;
      rtc_div_r <= 3'h0;
    end else if (clk_en) begin
      // The divider runs whether or not it is selected.
      div12_r <= div12_tick ? 4'h0 : 4'(div12_r + 4'h1);
      // The rtc divider counts in every mode so captures stay periodic.
      if (rtc_rise) begin
        rtc_div_r <= 3'(rtc_div_r + 3'h1);
      end
    end
  end

  // --------------------------------------------------------------------
  // Counter and reload flops.
  // --------------------------------------------------------------------
  // A software write to a counter byte wins over the count in that cycle.

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      counter_low_byte_r <= srtmr_pkg::SRTMR_RST_BYTE;
      counter_high_byte_r <= srtmr_pkg::SRTMR_RST_BYTE;
    end else if (clk_en) begin
      counter_low_byte_r <= (wr & hit_clo) ? wb : cnt_lo_nxt;
      counter_high_byte_r <= (wr & hit_chi) ? wb : cnt_hi_nxt;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      reload_low_byte_r <= srtmr_pkg::SRTMR_RST_BYTE;
      reload_high_byte_r <= srtmr_pkg::SRTMR_RST_BYTE;
    end else if (clk_en) begin
      // A capture wins over a reload write in the same cycle.
      if (cap_ev) begin
        reload_low_byte_r <= counter_low_byte_r;
        reload_high_byte_r <= counter_high_byte_r;
      end else begin
        if (wr & hit_rlo) reload_low_byte_r <= wb;
        if (wr & hit_rhi) reload_high_byte_r <= wb;
      end
    end
  end

  // --------------------------------------------------------------------
  // Control, status and interrupt enable flops.
  // --------------------------------------------------------------------
  // The flag bits take their hardware set or the written value; the
  // other control bits follow software only.

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      timer_control_reg_r <= srtmr_pkg::SRTMR_RST_BYTE;
      clock_control_reg_r <= 2'h0;
      global_tien_r <= 1'b0;
      mask_r <= '0;
      stat_r <= '0;
    end else if (clk_en) begin
      timer_control_reg_r <= {hflag_nxt, lflag_nxt, ctrl_lo_nxt};
      if (wr & hit_ckc) clock_control_reg_r <= wb[1:0];
      if (wr & hit_ien) global_tien_r <= wb[srtmr_pkg::SRTMR_B_TIEN];
      if (wr & hit_msk) mask_r <= wb[srtmr_pkg::SRTMR_STAT_W-1:0];
      stat_r <= stat_nxt;
    end
  end

  // --------------------------------------------------------------------
  // Bus response and interrupt output flops.
  // --------------------------------------------------------------------
  // Every port below comes straight from one of these flops.

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_r <= 32'h00000000;
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      timer_irq_r <= 1'b0;
      irq_r <= 1'b0;
    end else if (clk_en) begin
      // pready is a one-cycle pulse one edge after the access is taken.
      pready_r <= acc;
      pslverr_r <= acc & ~mapped;
      if (rd) prdata_r <= rdata_sel;
      timer_irq_r <= tirq_nxt;
      // The mask line is one cycle behind the status register.
      irq_r <= |(stat_r & mask_r);
    end
  end

  // --------------------------------------------------------------------
  // Ports.
  // --------------------------------------------------------------------
  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign timer_irq = timer_irq_r;
  assign irq = irq_r;

endmodule
`default_nettype wire

/* File: srtmr_timer_chk.sv */
// Checker for the reload/capture timer: APB handshake and interrupt lines.
// Sees only the timer's ports and is bound to every srtmr_timer.
`timescale 1ns/100ps
`default_nettype none
module srtmr_timer_chk (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic rtc_clk_in,
  input wire logic cmp0_in,
  input wire logic timer_irq,
  input wire logic irq
);
  wire logic take = psel && penable && clk_en && !pready;
  wire logic wr_go = take && pwrite;
  wire logic wr_ctl = wr_go && paddr == {24'h0, srtmr_pkg::SRTMR_OFS_CTRL};
  wire logic wr_ien = wr_go && paddr == {24'h0, srtmr_pkg::SRTMR_OFS_IEN};
  wire logic wr_msk = wr_go && paddr == {24'h0, srtmr_pkg::SRTMR_OFS_MASK};
  default clocking dck @(posedge pclk); endclocking
  default disable iff (!presetn);
  chk_ready_follows: assert property (take |=> pready)
    else $error("no pready after access");
  chk_ready_pulse: assert property (pready |=> !pready)
    else $error("pready too long");
  chk_err_unmapped: assert property (
    take && (paddr > 32'h20 || paddr[1:0] != 2'h0) |=> pslverr)
    else $error("no error on unmapped access");
  chk_rdata_hold: assert property (
    !(take && !pwrite) |=> $stable(prdata))
    else $error("read data moved without a read");
  chk_fast_rsvd: assert property (
    pready && !pwrite && paddr == {24'h0, srtmr_pkg::SRTMR_OFS_CLKCON}
    |-> prdata[31:2] == 30'h0)
    else $error("reserved clock bits not zero");
  chk_ien_off: assert property (
    wr_ien && !pwdata[srtmr_pkg::SRTMR_B_TIEN] ##1 clk_en ##1 clk_en
    |=> !timer_irq)
    else $error("timer irq despite enable off");
  chk_mask_off: assert property (
    wr_msk && pwdata[2:0] == 3'h0 ##1 clk_en ##1 clk_en |=> !irq)
    else $error("irq despite full mask");
  chk_flag_sticky: assert property (
    timer_irq && !$past(wr_ctl || wr_ien, 2) |=> timer_irq)
    else $error("overflow flag cleared by hardware");
endmodule
bind srtmr_timer srtmr_timer_chk u_srtmr_timer_chk (.pclk(pclk),
  .presetn(presetn), .clk_en(clk_en), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .rtc_clk_in(rtc_clk_in),
  .cmp0_in(cmp0_in), .timer_irq(timer_irq), .irq(irq));
`default_nettype wire
